/* core/mis_pkg.sv */
// constants, types and helpers shared by the interrupt sequencer files
package mis_pkg;

  // ----------------------------------------------------------------
  // sources and vectors
  // ----------------------------------------------------------------
  localparam int NSRC = 21;
  localparam int NMASK = 19;
  localparam logic [4:0] SRC_WDT = 5'h00;
  localparam logic [4:0] SRC_NMI = 5'h01;
  localparam logic [4:0] SRC_FIRST_MASKABLE = 5'h02;
  localparam logic [15:0] VEC_TABLE [0:20] = '{
    16'h0008, 16'h000A, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0020,
    16'h0024, 16'h002E, 16'h0030, 16'h0032, 16'h0040, 16'h004A, 16'h0058,
    16'h005A, 16'h0060, 16'h0068, 16'h006A, 16'h006E, 16'h0070, 16'h0076};
  localparam logic [15:0] SWI_VEC_BASE = 16'h0080;

  // ----------------------------------------------------------------
  // saved word layout and status word fields
  // ----------------------------------------------------------------
  localparam int SAVE_W = 28;
  localparam int SV_PC_LSB = 0;
  localparam int SV_CSR_LSB = 16;
  localparam int SV_PSW_LSB = 20;
  localparam int PSW_MIE_BIT = 3;
  localparam int PSW_LVL_LSB = 0;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_ONE = 2'h1;
  localparam logic [1:0] LVL_TWO = 2'h2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_REQ = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_SAVE1 = 8'h18;
  localparam logic [7:0] OFS_SAVE2 = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic RST_MIE = 1'b0;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam int EV_MASK_ENTRY = 0;
  localparam int EV_NMI_ENTRY = 1;
  localparam int EV_SWI_ENTRY = 2;
  localparam int EV_RETURN = 3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_FIRST = 4'b0100,
    ST_RET = 4'b1000
  } mis_state_t;

  typedef enum logic [2:0] {
    KIND_MASK = 3'b001,
    KIND_NMI = 3'b010,
    KIND_SWI = 3'b100
  } mis_kind_t;

  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    if (idx < 5'(NSRC)) begin
      return VEC_TABLE[idx];
    end
    return 16'h0000;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* core/mis_prio_sel.sv */
// fixed priority selector with vector lookup
`timescale 1ns/1ps
module mis_prio_sel
  import mis_pkg::*;
(
  mis_sel_if.sel sif
);
  logic [20:0] eligible;
  logic found;
  logic [4:0] idx;

  // maskable sources need both enables, the two top sources pass always
  assign eligible = sif.pending & {sif.enable & {19{sif.master_en}}, 2'b11};

  // scan from lowest priority so the highest one wins
  always_comb begin
    found = 1'b0;
    idx = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        idx = 5'(i);
      end
    end
  end

  assign sif.valid = found;
  assign sif.index = idx;
  assign sif.vector = vec_of(idx);
endmodule

/* core/mis_sel_if.sv */
// selection signals between the sequencer and its priority selector
`timescale 1ns/1ps
interface mis_sel_if;
  logic [20:0] pending;
  logic [18:0] enable;
  logic master_en;
  logic valid;
  logic [4:0] index;
  logic [15:0] vector;
  modport sel (input pending, input enable, input master_en,
               output valid, output index, output vector);
  modport ctl (output pending, output enable, output master_en,
               input valid, input index, input vector);
endinterface

/* core/mis_shadow_regs.sv */
// per-level storage of return address, code segment and status
`timescale 1ns/1ps
module mis_shadow_regs
  import mis_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_lvl1,
  input wire logic wr_lvl2,
  input wire logic [SAVE_W-1:0] wr_word,
  output logic [SAVE_W-1:0] lvl1_word,
  output logic [SAVE_W-1:0] lvl2_word
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl1_word <= '0;
    end else if (wr_lvl1) begin
      lvl1_word <= wr_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl2_word <= '0;
    end else if (wr_lvl2) begin
      lvl2_word <= wr_word;
    end
  end
endmodule

/* core/mis_top.sv */
// interrupt sequencer: request flags, priority, entry and return sequencing
//
// Summary of operation
// - maskable sources need master enable and their own enable to request.
// - watchdog and pin NMI ignore every enable flag.
// - accepted source loads its fixed vector table address into the PC.
// - simultaneous requests served by fixed priority, lower ones stay pending.
// - maskable interrupt taken only while master enable is one.
// - maskable entry saves to level 1, clears master enable, level becomes 1.
// - non-maskable entry saves to level 2, level 2, master enable kept.
// - software trap does the level 1 entry with an operand-chosen vector.
// - new requests wait until the handler's first instruction completes.
// - after a data segment prefix, acceptance waits for the next instruction.
// - return restores PC and status from the current level's storage.
// - source events set request flags regardless of enables.
// - software writing one to a request flag raises a normal request.
// - request flag clears when its request is accepted.
// - writes to request or enable registers take effect after one instruction.
`timescale 1ns/1ps
module mis_top
  import mis_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [20:0] src_event,
  input wire logic [15:0] cpu_pc,
  input wire logic [3:0] cpu_csr,
  input wire logic [7:0] cpu_psw,
  input wire logic instr_done,
  input wire logic dsr_prefix,
  input wire logic software_trap_instr,
  input wire logic [5:0] trap_operand,
  input wire logic return_from_trap_instr,
  output logic pc_load,
  output logic [15:0] pc_load_addr,
  output logic psw_load,
  output logic [7:0] psw_load_val,
  output logic master_irq_enable,
  output logic [1:0] exception_level_field,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mis_state_t st_r;
  mis_kind_t kind_r;
  logic [20:0] request_flags_reg_r;
  logic [18:0] per_source_enable_regs_r;
  logic mie_r;
  logic [1:0] exception_level_field_r;
  logic dsr_block_r;
  logic wr_hold_r;
  logic [4:0] taken_idx_r;
  logic [15:0] pc_load_addr_r;
  logic [7:0] psw_load_val_r;
  logic [3:0] irq_status_r;
  logic [3:0] irq_mask_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  mis_sel_if sif ();
  logic [SAVE_W-1:0] lvl1_word;
  logic [SAVE_W-1:0] lvl2_word;
  logic [SAVE_W-1:0] save_word;
  logic [7:0] status_now;
  logic hw_accept;
  logic swi_accept;
  logic rti_take;
  logic wr_commit;
  logic rd_take;
  logic [3:0] events;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;
  logic [SAVE_W-1:0] cur_save;

  // ----------------------------------------------------------------
  // selection and acceptance
  // ----------------------------------------------------------------
  assign sif.pending = request_flags_reg_r;
  assign sif.enable = per_source_enable_regs_r;
  assign sif.master_en = mie_r;

  mis_prio_sel u_sel (
    .sif(sif.sel)
  );

  assign rti_take = return_from_trap_instr && (st_r == ST_IDLE || st_r == ST_FIRST);
  assign swi_accept = software_trap_instr && st_r == ST_IDLE && !return_from_trap_instr;
  // held off in the first-instruction window, after a prefix, after a write
  assign hw_accept = st_r == ST_IDLE && sif.valid && !dsr_block_r && !dsr_prefix && !wr_hold_r
                     && !software_trap_instr && !return_from_trap_instr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (rti_take) begin
            st_r <= ST_RET;
          end else if (swi_accept || hw_accept) begin
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          st_r <= ST_FIRST;
        end
        ST_FIRST: begin
          if (rti_take) begin
            st_r <= ST_RET;
          end else if (instr_done) begin
            st_r <= ST_IDLE;
          end
        end
        ST_RET: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_r <= KIND_MASK;
      taken_idx_r <= 5'h00;
    end else if (swi_accept) begin
      kind_r <= KIND_SWI;
    end else if (hw_accept) begin
      kind_r <= (sif.index < SRC_FIRST_MASKABLE) ? KIND_NMI : KIND_MASK;
      taken_idx_r <= sif.index;
    end
  end

  assign cur_save = (exception_level_field_r == LVL_TWO) ? lvl2_word : lvl1_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_load_addr_r <= 16'h0000;
      psw_load_val_r <= 8'h00;
    end else if (rti_take) begin
      pc_load_addr_r <= cur_save[SV_PC_LSB +: 16];
      psw_load_val_r <= cur_save[SV_PSW_LSB +: 8];
    end else if (swi_accept) begin
      pc_load_addr_r <= SWI_VEC_BASE + {9'h000, trap_operand, 1'b0};
    end else if (hw_accept) begin
      pc_load_addr_r <= sif.vector;
    end
  end

  // ----------------------------------------------------------------
  // saving and level handling
  // ----------------------------------------------------------------
  always_comb begin
    status_now = cpu_psw;
    status_now[PSW_MIE_BIT] = mie_r;
    status_now[PSW_LVL_LSB +: 2] = exception_level_field_r;
  end

  assign save_word = {status_now, cpu_csr, cpu_pc};

  mis_shadow_regs u_shadow (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_lvl1(st_r == ST_SHIFT && kind_r != KIND_NMI),
    .wr_lvl2(st_r == ST_SHIFT && kind_r == KIND_NMI),
    .wr_word(save_word),
    .lvl1_word(lvl1_word),
    .lvl2_word(lvl2_word)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exception_level_field_r <= LVL_NONE;
    end else if (st_r == ST_SHIFT) begin
      exception_level_field_r <= (kind_r == KIND_NMI) ? LVL_TWO : LVL_ONE;
    end else if (st_r == ST_RET) begin
      exception_level_field_r <= psw_load_val_r[PSW_LVL_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mie_r <= RST_MIE;
    end else if (st_r == ST_SHIFT) begin
      if (kind_r != KIND_NMI) begin
        mie_r <= 1'b0;
      end
    end else if (st_r == ST_RET) begin
      mie_r <= psw_load_val_r[PSW_MIE_BIT];
    end else if (wr_commit && awaddr_r == OFS_CTRL && wstrb_r[0]) begin
      mie_r <= wdata_r[0];
    end
  end

  // ----------------------------------------------------------------
  // deferral windows
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsr_block_r <= 1'b0;
    end else if (dsr_prefix) begin
      dsr_block_r <= 1'b1;
    end else if (instr_done) begin
      dsr_block_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_hold_r <= 1'b0;
    end else if (wr_commit && (awaddr_r == OFS_REQ || awaddr_r == OFS_ENABLE
                               || awaddr_r == OFS_CTRL)) begin
      wr_hold_r <= 1'b1;
    end else if (instr_done) begin
      wr_hold_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request and enable flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    logic [31:0] nxt;
    nxt = {11'h000, request_flags_reg_r};
    if (!aresetn) begin
      request_flags_reg_r <= 21'h000000;
    end else begin
      if (wr_commit && awaddr_r == OFS_REQ) begin
        nxt = apply_strb(nxt, wdata_r, wstrb_r);
      end
      if (hw_accept) begin
        nxt[sif.index] = 1'b0;
      end
      request_flags_reg_r <= nxt[20:0] | src_event;
    end
  end

  always_ff @(posedge aclk) begin
    logic [31:0] nxt;
    nxt = {13'h0000, per_source_enable_regs_r};
    if (!aresetn) begin
      per_source_enable_regs_r <= 19'h00000;
    end else if (wr_commit && awaddr_r == OFS_ENABLE) begin
      nxt = apply_strb(nxt, wdata_r, wstrb_r);
      per_source_enable_regs_r <= nxt[18:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  assign events = {st_r == ST_RET, st_r == ST_SHIFT && kind_r == KIND_SWI,
                   st_r == ST_SHIFT && kind_r == KIND_NMI,
                   st_r == ST_SHIFT && kind_r == KIND_MASK};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= 4'h0;
    end else if (rd_take && {s_axi_araddr[7:2], 2'b00} == OFS_IRQ_STATUS) begin
      irq_status_r <= events;
    end else begin
      irq_status_r <= irq_status_r | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (wr_commit && awaddr_r == OFS_IRQ_MASK && wstrb_r[0]) begin
      irq_mask_r <= wdata_r[3:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign wr_commit = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ok = awaddr_r == OFS_REQ || awaddr_r == OFS_ENABLE || awaddr_r == OFS_CTRL
                 || awaddr_r == OFS_IRQ_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && !aw_held_r) begin
      aw_held_r <= 1'b1;
      awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_commit) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && !w_held_r) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign rd_take = s_axi_arvalid && !rvalid_r;

  always_comb begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      OFS_REQ: rd_mux = {11'h000, request_flags_reg_r};
      OFS_ENABLE: rd_mux = {13'h0000, per_source_enable_regs_r};
      OFS_CTRL: rd_mux = {31'h00000000, mie_r};
      OFS_STATE: rd_mux = {10'h000, sif.vector, st_r, exception_level_field_r};
      OFS_IRQ_STATUS: rd_mux = {28'h0000000, irq_status_r};
      OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_r};
      OFS_SAVE1: rd_mux = {4'h0, lvl1_word};
      OFS_SAVE2: rd_mux = {4'h0, lvl2_word};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pc_load = st_r == ST_SHIFT || st_r == ST_RET;
  assign pc_load_addr = pc_load_addr_r;
  assign psw_load = st_r == ST_RET;
  assign psw_load_val = psw_load_val_r;
  assign master_irq_enable = mie_r;
  assign exception_level_field = exception_level_field_r;
  assign irq = |(irq_status_r & irq_mask_r);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_mask_take;
    hw_accept && sif.index >= SRC_FIRST_MASKABLE;
  endsequence
  sequence s_nmi_take;
    hw_accept && sif.index < SRC_FIRST_MASKABLE;
  endsequence
  sequence s_shift;
    st_r == ST_SHIFT;
  endsequence

  AST_MASK_GATE: assert property (sif.valid && sif.index >= SRC_FIRST_MASKABLE |->
      mie_r && per_source_enable_regs_r[sif.index - SRC_FIRST_MASKABLE])
    else $error("maskable source selected while disabled");
  AST_NMI_PASS: assert property (request_flags_reg_r[SRC_WDT] |->
      sif.valid && sif.index == SRC_WDT)
    else $error("watchdog request not selected");
  AST_PRIO: assert property (sif.valid && sif.index > SRC_WDT |->
      !request_flags_reg_r[SRC_WDT]
      && (sif.index == SRC_NMI || !request_flags_reg_r[SRC_NMI]))
    else $error("lower source chosen over pending non-maskable");
  AST_VECTOR: assert property (hw_accept |=> s_shift ##0
      pc_load && pc_load_addr == vec_of(taken_idx_r))
    else $error("wrong vector on entry");
  AST_MASK_ENTRY: assert property (s_mask_take ##1 s_shift |=>
      !mie_r && exception_level_field_r == LVL_ONE && lvl1_word[SV_PC_LSB +: 16] == $past(cpu_pc))
    else $error("maskable entry did not save level one");
  AST_MASK_MIE: assert property (s_mask_take |-> mie_r)
    else $error("maskable taken with master enable off");
  AST_NMI_ENTRY: assert property (s_nmi_take ##1 s_shift |=>
      exception_level_field_r == LVL_TWO && mie_r == $past(mie_r)
      && lvl2_word[SV_CSR_LSB +: 4] == $past(cpu_csr))
    else $error("non-maskable entry wrong");
  AST_SWI_ENTRY: assert property (swi_accept |=> s_shift ##1
      (!mie_r && exception_level_field_r == LVL_ONE))
    else $error("software trap entry wrong");
  AST_FIRST_WAIT: assert property (st_r == ST_FIRST && !instr_done && !rti_take |=>
      st_r == ST_FIRST && !pc_load)
    else $error("accepted inside first instruction window");
  AST_DSR_BLOCK: assert property (dsr_block_r || dsr_prefix |-> !hw_accept)
    else $error("accepted after prefix");
  AST_RETURN: assert property (rti_take && exception_level_field_r == LVL_ONE |=>
      psw_load && pc_load_addr == $past(lvl1_word[SV_PC_LSB +: 16]))
    else $error("return address not restored");
  AST_SET: assert property (##1 (request_flags_reg_r & $past(src_event))
      == $past(src_event))
    else $error("event did not set request flag");
  AST_CLEAR: assert property (hw_accept && !src_event[sif.index] |=>
      !request_flags_reg_r[taken_idx_r])
    else $error("request flag not cleared on accept");
  AST_WR_HOLD: assert property (wr_hold_r |-> !hw_accept)
    else $error("accepted before an instruction after write");
endmodule

/* testbench/mis_cpu_model.sv */
// cpu core stand-in that follows the sequencer's load pulses
`timescale 1ns/1ps
module mis_cpu_model (
  input wire logic aclk,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_addr,
  input wire logic psw_load,
  input wire logic [7:0] psw_load_val,
  output logic [15:0] cpu_pc,
  output logic [3:0] cpu_csr,
  output logic [7:0] cpu_psw
);
  initial cpu_pc = 16'h1000;
  initial cpu_psw = 8'h00;
  assign cpu_csr = 4'h5;
  // an nmi handler can nest inside a level 1 handler; leaving is by the return pulse only
  always @(posedge aclk) begin
    if (pc_load) begin
      cpu_pc <= pc_load_addr;
    end
    if (psw_load) begin
      cpu_psw <= psw_load_val;
    end
  end
endmodule

/* testbench/test_mis_top.sv */
// self-checking bench of the interrupt sequencer
`timescale 1ns/1ps
module test_mis_top;
  import mis_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [20:0] src_event = 21'h0;
  logic instr_done = 1'h0, dsr_prefix = 1'h0, software_trap_instr = 1'h0;
  logic return_from_trap_instr = 1'h0;
  logic [5:0] trap_operand = 6'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pc_load, psw_load, master_irq_enable, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, exception_level_field;
  logic [31:0] s_axi_rdata;
  logic [15:0] pc_load_addr, cpu_pc;
  logic [7:0] psw_load_val, cpu_psw;
  logic [3:0] cpu_csr;
  int fails = 0;
  int tests_run = 0;
  logic [15:0] vt [21] = '{16'h0008, 16'h000A, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
    16'h0020, 16'h0024, 16'h002E, 16'h0030, 16'h0032, 16'h0040, 16'h004A, 16'h0058,
    16'h005A, 16'h0060, 16'h0068, 16'h006A, 16'h006E, 16'h0070, 16'h0076};
  always #50 aclk = ~aclk;
  mis_top u_mis_top (.*);
  mis_cpu_model u_mis_cpu_model (.*);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task axr(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(a < 8'h20 ? RESP_OKAY : RESP_SLVERR));
  endtask
  task wpc(input logic [15:0] e);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (pc_load !== 1'h1 && n < 30);
    chk(32'(pc_load), 32'h1);
    chk(32'(pc_load_addr), 32'(e));
  endtask
  task quiet(input int k);
    repeat (k) begin
      @(negedge aclk);
      chk(32'(pc_load), 32'h0);
    end
  endtask
  // pulse kinds: instruction done, prefix, trap, return
  task pls(input int w);
    @(posedge aclk);
    case (w)
      0: instr_done <= 1'h1;
      1: dsr_prefix <= 1'h1;
      2: software_trap_instr <= 1'h1;
      default: return_from_trap_instr <= 1'h1;
    endcase
    @(posedge aclk);
    {instr_done, dsr_prefix, software_trap_instr, return_from_trap_instr} <= 4'h0;
  endtask
  task ev(input int i);
    @(posedge aclk);
    src_event[i] <= 1'h1;
    @(posedge aclk);
    src_event <= 21'h0;
  endtask
  task rt(input logic [15:0] e);
    pls(3);
    wpc(e);
    chk(32'(psw_load), 32'h1);
  endtask
  task results();
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    results();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk(32'({master_irq_enable, exception_level_field, irq}), 32'h0);
    axr(OFS_CTRL, 32'h0);
    axw(OFS_ENABLE, 32'h7FFFF, RESP_OKAY);
    axw(OFS_IRQ_MASK, 32'hF, RESP_OKAY);
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    pls(0);
    for (int i = 0; i < NSRC; i++) begin
      ev(i);
      wpc(vt[i]);
      @(negedge aclk);
      chk(32'({master_irq_enable, exception_level_field}), i < 2 ? 32'h6 : 32'h1);
      rt(16'h1000);
      @(negedge aclk);
      chk(32'({master_irq_enable, exception_level_field}), 32'h4);
    end
    axr(OFS_SAVE1, 32'h0851000);
    axr(OFS_SAVE2, 32'h0851000);
    chk(32'(irq), 32'h1);
    axr(OFS_IRQ_STATUS, 32'hB);
    chk(32'(irq), 32'h0);
    axw(OFS_REQ, 32'h100008, RESP_OKAY);
    quiet(4);
    pls(0);
    wpc(16'h0012);
    ev(1);
    quiet(3);
    pls(0);
    wpc(16'h000A);
    axr(OFS_REQ, 32'h100000);
    rt(16'h0012);
    rt(16'h1000);
    wpc(16'h0076);
    rt(16'h1000);
    axw(OFS_CTRL, 32'h0, RESP_OKAY);
    pls(0);
    ev(5);
    quiet(4);
    axr(OFS_REQ, 32'h20);
    ev(0);
    wpc(16'h0008);
    rt(16'h1000);
    axw(OFS_ENABLE, 32'h7FFF7, RESP_OKAY);
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    pls(0);
    quiet(4);
    pls(1);
    ev(2);
    quiet(3);
    pls(0);
    wpc(16'h0010);
    rt(16'h1000);
    axr(OFS_IRQ_STATUS, 32'hB);
    axw(OFS_IRQ_MASK, 32'h3, RESP_OKAY);
    trap_operand <= 6'h03;
    pls(2);
    wpc(16'h0086);
    @(negedge aclk);
    chk(32'({master_irq_enable, exception_level_field}), 32'h1);
    rt(16'h1000);
    chk(32'(irq), 32'h0);
    axr(OFS_IRQ_STATUS, 32'hC);
    axw(8'h40, 32'h1, RESP_SLVERR);
    axr(8'h40, 32'h0);
    axw(OFS_STATE, 32'h1, RESP_SLVERR);
    results();
  end
endmodule
